/* src/embp_pkg.sv */
package embp_pkg;
    // widths
    localparam int ADDR_W = 27;
    localparam int DATA_W = 32;
    localparam int BANKS = 8;
    localparam int LANES = 4;
    localparam int BANK_BITS = 3;
    // boot configuration codes
    localparam logic [1:0] BOOT_NAND = 2'h0;
    localparam logic [1:0] BOOT_W16 = 2'h1;
    localparam logic [1:0] BOOT_W32 = 2'h2;
    localparam logic [1:0] BOOT_TEST = 2'h3;
    // bus width codes
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    // bank size codes: region is 2^min(SIZE_BASE + code, 24) bytes, never more than the bank
    localparam int SIZE_BASE = 20;
    localparam int SIZE_CODE_W = 3;
    localparam int CYC_W = 4;
    localparam logic [3:0] CYC_MIN = 4'h1;
    // states
    typedef enum logic [1:0] {
        EMBP_IDLE = 2'b00,
        EMBP_ACCESS = 2'b01,
        EMBP_HOLD = 2'b10
    } embp_state_t;
endpackage

/* src/embp_dec_if.sv */
`timescale 1ns/1ns
`default_nettype none
// carries the decode request and answer between top and decoder
interface embp_dec_if;
    logic [26:0] addr;
    logic [23:0] size_codes;
    logic [7:0] sel;
    logic hit;
    modport requester (output addr, output size_codes, input sel, input hit);
    modport decoder (input addr, input size_codes, output sel, output hit);
endinterface
`default_nettype wire

/* src/embp_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
// bank decoder: the top three address bits (the bank field) pick the bank
module embp_decoder (
    embp_dec_if.decoder dif
);
    localparam int AW = embp_pkg::ADDR_W;
    localparam int BB = embp_pkg::BANK_BITS;
    logic [BB-1:0] bank_idx;
    assign bank_idx = dif.addr[AW-1 -: BB];

    // one-hot select when offset within the bank's programmed size
    genvar g;
    generate
        for (g = 0; g < embp_pkg::BANKS; g++) begin : g_bank
            logic [2:0] code;
            logic [AW-BB-1:0] offs;
            logic [AW-BB-1:0] limit;
            assign code = dif.size_codes[g*embp_pkg::SIZE_CODE_W +: embp_pkg::SIZE_CODE_W];
            assign offs = dif.addr[AW-BB-1:0];
            assign limit = (AW-BB)'(1) << (embp_pkg::SIZE_BASE + int'(code));
            assign dif.sel[g] = (bank_idx == BB'(g)) &&
                ((int'(code) + embp_pkg::SIZE_BASE >= AW - BB) || (offs < limit));
        end
    endgenerate
    assign dif.hit = |dif.sel;
endmodule // embp_decoder
`default_nettype wire

/* src/embp_bus.sv */
`timescale 1ns/1ns
`default_nettype none
module embp_bus (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    // configuration
    input wire logic [1:0] BOOT_CONFIG_PINS_IN,
    input wire logic [23:0] BANK_CYCLES_IN,
    input wire logic [23:0] BANK_SIZE_IN,
    input wire logic [13:0] BANK_WIDTH_IN,
    output logic [1:0] BANK0_WIDTH_OUT,
    output logic TEST_MODE_OUT,
    output logic NAND_BOOT_OUT,
    // internal request
    input wire logic REQ_IN,
    input wire logic REQ_WRITE_IN,
    input wire logic [26:0] REQ_ADDR_IN,
    input wire logic [31:0] REQ_WDATA_IN,
    input wire logic [3:0] REQ_LANES_IN,
    output logic REQ_BUSY_OUT,
    output logic REQ_DONE_OUT,
    output logic REQ_ERR_OUT,
    output logic [31:0] REQ_RDATA_OUT,
    // memory pins
    output logic [26:0] ADDR_OUT,
    output logic ADDR_OE_OUT,
    input wire logic [31:0] DATA_IN,
    output logic [31:0] DATA_OUT,
    output logic DATA_OE_OUT,
    output logic [7:0] BANK_SELECT_N_OUT,
    output logic WRITE_STROBE_N_OUT,
    output logic READ_STROBE_N_OUT,
    output logic [3:0] HALFWORD_LANE_ENABLE_N_OUT,
    output logic STROBE_OE_OUT,
    input wire logic CYCLE_EXTEND_N_IN,
    // bus hold
    input wire logic HOLD_REQUEST_N_IN,
    output logic HOLD_GRANT_N_OUT
);
    localparam int CW = embp_pkg::CYC_W;

    // pin synchronisers
    logic [1:0] boot_s1_q, boot_s2_q;
    logic ext_s1_q, ext_s2_q, hreq_s1_q, hreq_s2_q;
    logic [31:0] data_s1_q, data_s2_q;
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            boot_s1_q <= 2'h0;
            boot_s2_q <= 2'h0;
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
            hreq_s1_q <= 1'b1;
            hreq_s2_q <= 1'b1;
            data_s1_q <= 32'h0;
            data_s2_q <= 32'h0;
        end else begin
            boot_s1_q <= BOOT_CONFIG_PINS_IN;
            boot_s2_q <= boot_s1_q;
            ext_s1_q <= CYCLE_EXTEND_N_IN;
            ext_s2_q <= ext_s1_q;
            hreq_s1_q <= HOLD_REQUEST_N_IN;
            hreq_s2_q <= hreq_s1_q;
            data_s1_q <= DATA_IN;
            data_s2_q <= data_s1_q;
        end
    end

    // strap capture: first cycles after release latch the boot pins once
    logic [1:0] strap_cnt_q;
    logic [1:0] boot_q;
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            strap_cnt_q <= 2'h0;
            boot_q <= embp_pkg::BOOT_NAND;
        end else if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == 2'h2) begin
                boot_q <= boot_s2_q;
            end
        end
    end
    logic strap_done;
    assign strap_done = (strap_cnt_q == 2'h3);

    // strap decode into mode outputs
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            BANK0_WIDTH_OUT <= embp_pkg::WIDTH_16;
            TEST_MODE_OUT <= 1'b0;
            NAND_BOOT_OUT <= 1'b0;
        end else begin
            case (boot_q)
                embp_pkg::BOOT_NAND: begin
                    BANK0_WIDTH_OUT <= embp_pkg::WIDTH_16;
                    NAND_BOOT_OUT <= 1'b1;
                    TEST_MODE_OUT <= 1'b0;
                end
                embp_pkg::BOOT_W16: begin
                    BANK0_WIDTH_OUT <= embp_pkg::WIDTH_16;
                    NAND_BOOT_OUT <= 1'b0;
                    TEST_MODE_OUT <= 1'b0;
                end
                embp_pkg::BOOT_W32: begin
                    BANK0_WIDTH_OUT <= embp_pkg::WIDTH_32;
                    NAND_BOOT_OUT <= 1'b0;
                    TEST_MODE_OUT <= 1'b0;
                end
                default: begin
                    BANK0_WIDTH_OUT <= embp_pkg::WIDTH_32;
                    NAND_BOOT_OUT <= 1'b0;
                    TEST_MODE_OUT <= 1'b1;
                end
            endcase
        end
    end

    // bank decode
    embp_dec_if dif ();
    assign dif.addr = REQ_ADDR_IN;
    assign dif.size_codes = BANK_SIZE_IN;
    embp_decoder u_dec (
        .dif(dif)
    );

    // bank index and width lookup
    function automatic logic [2:0] onehot_idx(input logic [7:0] oh);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (oh[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction
    logic [2:0] bidx;
    logic [1:0] width;
    logic [CW-1:0] cycles;
    assign bidx = onehot_idx(dif.sel);
    assign width = (bidx == 3'h0) ? BANK0_WIDTH_OUT : BANK_WIDTH_IN[(bidx-3'h1)*2 +: 2];
    assign cycles = BANK_CYCLES_IN[bidx*3 +: 3] + embp_pkg::CYC_MIN;

    // lane enables: 16-bit uses two lanes, 8-bit only lane 0
    function automatic logic [3:0] lane_mask(input logic [1:0] w, input logic [3:0] l);
        case (w)
            embp_pkg::WIDTH_8: lane_mask = 4'h1;
            embp_pkg::WIDTH_16: lane_mask = {2'h0, l[1:0] | l[3:2]};
            default: lane_mask = l;
        endcase
    endfunction

    // access state machine
    embp_pkg::embp_state_t state_q;
    logic [CW-1:0] cnt_q;
    logic wr_q;
    always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_q <= embp_pkg::EMBP_IDLE;
            cnt_q <= '0;
            wr_q <= 1'b0;
            ADDR_OUT <= 27'h0;
            ADDR_OE_OUT <= 1'b1;
            DATA_OUT <= 32'h0;
            DATA_OE_OUT <= 1'b0;
            BANK_SELECT_N_OUT <= 8'hff;
            WRITE_STROBE_N_OUT <= 1'b1;
            READ_STROBE_N_OUT <= 1'b1;
            HALFWORD_LANE_ENABLE_N_OUT <= 4'hf;
            STROBE_OE_OUT <= 1'b1;
            HOLD_GRANT_N_OUT <= 1'b1;
            REQ_BUSY_OUT <= 1'b1;
            REQ_DONE_OUT <= 1'b0;
            REQ_ERR_OUT <= 1'b0;
            REQ_RDATA_OUT <= 32'h0;
        end else begin
            REQ_DONE_OUT <= 1'b0;
            REQ_ERR_OUT <= 1'b0;
            case (state_q)
                embp_pkg::EMBP_IDLE: begin
                    REQ_BUSY_OUT <= !strap_done;
                    if (strap_done && !hreq_s2_q) begin
                        // release pins first, grant next cycle
                        ADDR_OE_OUT <= 1'b0;
                        DATA_OE_OUT <= 1'b0;
                        STROBE_OE_OUT <= 1'b0;
                        REQ_BUSY_OUT <= 1'b1;
                        state_q <= embp_pkg::EMBP_HOLD;
                    end else if (strap_done && REQ_IN && !dif.hit) begin
                        REQ_ERR_OUT <= 1'b1;
                    end else if (strap_done && REQ_IN) begin
                        ADDR_OUT <= REQ_ADDR_IN;
                        BANK_SELECT_N_OUT <= ~dif.sel;
                        WRITE_STROBE_N_OUT <= !REQ_WRITE_IN;
                        READ_STROBE_N_OUT <= REQ_WRITE_IN;
                        HALFWORD_LANE_ENABLE_N_OUT <= ~lane_mask(width, REQ_LANES_IN);
                        DATA_OUT <= REQ_WDATA_IN;
                        DATA_OE_OUT <= REQ_WRITE_IN;
                        wr_q <= REQ_WRITE_IN;
                        cnt_q <= cycles;
                        REQ_BUSY_OUT <= 1'b1;
                        state_q <= embp_pkg::EMBP_ACCESS;
                    end
                end
                embp_pkg::EMBP_ACCESS: begin
                    if (cnt_q > CW'(1)) begin
                        cnt_q <= cnt_q - CW'(1);
                    end else if (ext_s2_q) begin
                        if (!wr_q) begin
                            REQ_RDATA_OUT <= data_s2_q;
                        end
                        BANK_SELECT_N_OUT <= 8'hff;
                        WRITE_STROBE_N_OUT <= 1'b1;
                        READ_STROBE_N_OUT <= 1'b1;
                        HALFWORD_LANE_ENABLE_N_OUT <= 4'hf;
                        DATA_OE_OUT <= 1'b0;
                        REQ_DONE_OUT <= 1'b1;
                        REQ_BUSY_OUT <= 1'b0;
                        state_q <= embp_pkg::EMBP_IDLE;
                    end
                end
                embp_pkg::EMBP_HOLD: begin
                    if (hreq_s2_q) begin
                        HOLD_GRANT_N_OUT <= 1'b1;
                        ADDR_OE_OUT <= 1'b1;
                        STROBE_OE_OUT <= 1'b1;
                        REQ_BUSY_OUT <= 1'b0;
                        state_q <= embp_pkg::EMBP_IDLE;
                    end else begin
                        HOLD_GRANT_N_OUT <= 1'b0;
                    end
                end
                default: begin
                    state_q <= embp_pkg::EMBP_IDLE;
                end
            endcase
        end
    end
endmodule // embp_bus
`default_nettype wire

/* test/embp_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// pin level checks for the external bus block
module embp_monitor (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    // watched pins
    input wire logic [26:0] ADDR_OUT,
    input wire logic ADDR_OE_OUT,
    input wire logic DATA_OE_OUT,
    input wire logic STROBE_OE_OUT,
    input wire logic [7:0] BANK_SELECT_N_OUT,
    input wire logic WRITE_STROBE_N_OUT,
    input wire logic READ_STROBE_N_OUT,
    input wire logic CYCLE_EXTEND_N_IN,
    input wire logic HOLD_GRANT_N_OUT,
    input wire logic REQ_DONE_OUT,
    input wire logic TEST_MODE_OUT,
    input wire logic [1:0] BANK0_WIDTH_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RST_B_IN);
    // selects and strobes
    sel_onehot_a: assert property ($onehot0(~BANK_SELECT_N_OUT))
        else $error("more than one bank select low");
    sel_bank_a: assert property (BANK_SELECT_N_OUT != 8'hff |->
        !BANK_SELECT_N_OUT[ADDR_OUT[26:24]]) else $error("select not of address bank");
    strobe_excl_a: assert property (WRITE_STROBE_N_OUT || READ_STROBE_N_OUT)
        else $error("read and write strobes together");
    write_drive_a: assert property (!WRITE_STROBE_N_OUT |-> DATA_OE_OUT)
        else $error("write without data drive");
    read_float_a: assert property (!READ_STROBE_N_OUT |-> !DATA_OE_OUT)
        else $error("data driven during read");
    // hold handover, cycle extension and test mode width
    grant_float_a: assert property (!HOLD_GRANT_N_OUT |->
        !ADDR_OE_OUT && !DATA_OE_OUT && !STROBE_OE_OUT) else $error("pins driven in hold");
    grant_after_a: assert property ($fell(HOLD_GRANT_N_OUT) |->
        $past(!ADDR_OE_OUT) && $past(!STROBE_OE_OUT)) else $error("grant before release");
    extend_stall_a: assert property (!CYCLE_EXTEND_N_IN [*3] |=> !REQ_DONE_OUT)
        else $error("cycle finished while extended");
    boot_test_a: assert property (TEST_MODE_OUT |->
        BANK0_WIDTH_OUT == embp_pkg::WIDTH_32) else $error("test mode width wrong");
    cover property (!WRITE_STROBE_N_OUT ##1 WRITE_STROBE_N_OUT);
    cover property (!READ_STROBE_N_OUT ##1 READ_STROBE_N_OUT);
    cover property ($fell(HOLD_GRANT_N_OUT));
endmodule // embp_monitor
`default_nettype wire

/* test/embp_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// static memory on the far side of the pins
module embp_mem_model (
    // clock, strobes, address, write data and stall count
    input wire logic clk,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [26:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] stall,
    // answers
    output logic [31:0] rdata,
    output logic extend_n
);
    logic [31:0] mem [16];
    logic [3:0] cnt = 4'h0;
    logic act = 1'b0;
    // store writes, start an extension count on each new cycle
    always @(posedge clk) begin
        if (!wr_n) mem[addr[5:2]] <= wdata;
        act <= !(rd_n && wr_n);
        if (!(rd_n && wr_n) && !act) cnt <= stall;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    // released data lines float up to the pad pull-up level
    assign rdata = !rd_n ? mem[addr[5:2]] : 32'hffffffff;
    assign extend_n = (cnt == 4'h0);
endmodule // embp_mem_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    typedef struct {logic wr; logic [26:0] a; logic [31:0] d; logic [3:0] ln;
        logic [7:0] sel_n; logic [3:0] ln_n;} embp_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] boot = 2'h2;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic hold_n = 1'b1;
    logic [26:0] a = 27'h0;
    logic [31:0] d = 32'h0;
    logic [3:0] ln = 4'h0;
    logic [3:0] stall = 4'h0;
    logic busy, done, err, tm, nb, aoe, doe, soe, we_n, re_n, ext_n, gnt_n;
    logic [1:0] w0;
    logic [7:0] sel_n;
    logic [3:0] lane_n;
    logic [26:0] ao;
    logic [31:0] di, dout, rd;
    int n_fail = 0;
    int n_compared = 0;
    int i, c;
    embp_row_t rows [6] = '{
        '{1'b1, 27'h1000004, 32'hdeadbeef, 4'hf, 8'hfd, 4'h0},
        '{1'b0, 27'h1000004, 32'hdeadbeef, 4'hf, 8'hfd, 4'h0},
        '{1'b1, 27'h2000008, 32'ha5a5a5a5, 4'h1, 8'hfb, 4'he},
        '{1'b1, 27'h3000010, 32'hbeefbeef, 4'hc, 8'hf7, 4'hc},
        '{1'b1, 27'h70ffffc, 32'h12345678, 4'h3, 8'h7f, 4'hc},
        '{1'b0, 27'h70ffffc, 32'h12345678, 4'hf, 8'h7f, 4'h0}};
    embp_bus dut (.MCLK_IN(clk), .RST_B_IN(rst_n), .BOOT_CONFIG_PINS_IN(boot),
        .BANK_CYCLES_IN(24'h6db6db), .BANK_SIZE_IN(24'h0), .BANK_WIDTH_IN(14'h2a92),
        .BANK0_WIDTH_OUT(w0), .TEST_MODE_OUT(tm), .NAND_BOOT_OUT(nb), .REQ_IN(req),
        .REQ_WRITE_IN(wr), .REQ_ADDR_IN(a), .REQ_WDATA_IN(d), .REQ_LANES_IN(ln),
        .REQ_BUSY_OUT(busy), .REQ_DONE_OUT(done), .REQ_ERR_OUT(err), .REQ_RDATA_OUT(rd),
        .ADDR_OUT(ao), .ADDR_OE_OUT(aoe), .DATA_IN(di), .DATA_OUT(dout), .DATA_OE_OUT(doe),
        .BANK_SELECT_N_OUT(sel_n), .WRITE_STROBE_N_OUT(we_n), .READ_STROBE_N_OUT(re_n),
        .HALFWORD_LANE_ENABLE_N_OUT(lane_n), .STROBE_OE_OUT(soe),
        .CYCLE_EXTEND_N_IN(ext_n), .HOLD_REQUEST_N_IN(hold_n), .HOLD_GRANT_N_OUT(gnt_n));
    embp_mem_model mem (.clk(clk), .rd_n(re_n), .wr_n(we_n), .addr(ao), .wdata(dout),
        .stall(stall), .rdata(di), .extend_n(ext_n));
    // clock
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one access: pins while active, then completion
    task automatic go(input embp_row_t r, output int cyc);
        @(posedge clk) {req, wr, a, d, ln} <= {1'b1, r.wr, r.a, r.d, r.ln};
        cyc = 0;
        do begin @(posedge clk); #1 cyc++; end while (!busy && cyc < 20);
        chk(sel_n, r.sel_n);
        chk(lane_n, r.ln_n);
        chk(ao, r.a);
        chk({we_n, re_n, doe}, {!r.wr, r.wr, r.wr});
        if (r.wr) chk(dout, r.d);
        cyc = 0;
        do begin @(posedge clk) req <= 1'b0; #1 cyc++; end while (!done && cyc < 40);
        chk(done, 1'b1);
        if (!r.wr) chk(rd, r.d);
        chk({sel_n, we_n, re_n}, 10'h3ff);
    endtask
    initial begin
        // strap codes 3,0,1,2, each under a fresh reset
        for (i = 0; i < 4; i++) begin
            @(posedge clk) begin boot <= 2'(i + 3); rst_n <= 1'b0; end
            repeat (3) @(posedge clk);
            #1 chk({busy, gnt_n, sel_n, doe, aoe}, 12'hffd);
            @(posedge clk) rst_n <= 1'b1;
            repeat (6) @(posedge clk);
            #1 chk({w0, tm, nb}, {boot[1] ? embp_pkg::WIDTH_32 : embp_pkg::WIDTH_16,
                boot == 2'h3, boot == 2'h0});
        end
        @(posedge clk) boot <= 2'h1;
        repeat (4) @(posedge clk);
        #1 chk(w0, embp_pkg::WIDTH_32);
        foreach (rows[k]) begin
            go(rows[k], c);
            chk(c, 4);
        end
        // extended write cycle
        @(posedge clk) stall <= 4'h3;
        go(rows[0], c);
        chk(c >= 7, 1);
        // unmapped address gives an error and no select
        @(posedge clk) {stall, req, wr, a} <= {4'h0, 1'b1, 1'b0, 27'h1100000};
        for (i = 0; i < 10 && !err; i++) begin @(posedge clk); #1; end
        chk({err, sel_n, re_n}, 10'h3ff);
        @(posedge clk) {hold_n, req} <= 2'h0;
        for (i = 0; i < 10 && gnt_n; i++) begin @(posedge clk); #1; end
        chk({gnt_n, aoe, doe, soe}, 4'h0);
        @(posedge clk) {req, wr, a} <= {1'b1, 1'b0, 27'h1000004};
        repeat (5) @(posedge clk);
        #1 chk({sel_n, gnt_n}, 9'h1fe);
        // drop the held request with the hold so no stale access follows
        @(posedge clk) {hold_n, req} <= 2'h2;
        for (i = 0; i < 10 && !gnt_n; i++) begin @(posedge clk); #1; end
        chk({gnt_n, aoe, soe}, 3'h7);
        go(rows[1], c);
        chk(c, 4);
        conclude();
    end
    // watchdog
    initial begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule // tb
bind embp_bus embp_monitor mon (.*);
`default_nettype wire
